// File: core/ubt_usart.sv
// serial transmitter with biphase framing and oversampling receiver
`default_nettype none
module ubt_usart (
  // clock and reset
  input wire logic MCLK,
  input wire logic RESET_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ubt_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial line
  input wire logic SERIAL_IN,
  output logic SERIAL_OUT
);
  import ubt_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic tx_en;
    logic off_pend;
    logic [CFG_W-1:0] cfg;
    logic [BCFG_W-1:0] bcfg;
    logic [BAUD_W-1:0] baud;
    logic [8:0] thr;
    logic thr_sync;
    logic thr_full;
    ubt_tx_t txs;
    logic txd;
    logic [2:0] tdiv;
    logic [4:0] hc;
    logic [4:0] hend;
    logic [4:0] blen;
    logic [FRAME_W-1:0] fr;
    logic cmd;
    ubt_rx_t rxs;
    logic rx_prev;
    logic [3:0] lowcnt;
    logic [4:0] rxcnt;
    logic [4:0] rxper;
    logic [3:0] rxidx;
    logic [RXB_W-1:0] rxsh;
    logic [8:0] rxdata;
    logic rx_ready;
  } ubt_st_t;

  localparam ubt_st_t ST_RST = '{
    pready: 1'b0, pslverr: 1'b0, prdata: 32'h0,
    tx_en: 1'b0, off_pend: 1'b0,
    cfg: CFG_RST, bcfg: BCFG_RST, baud: BAUD_RST,
    thr: 9'h0, thr_sync: 1'b0, thr_full: 1'b0,
    txs: TX_IDLE, txd: 1'b1, tdiv: 3'h0, hc: 5'h0,
    hend: 5'h0, blen: 5'h0, fr: 13'h1fff, cmd: 1'b0,
    rxs: RX_HUNT, rx_prev: 1'b1, lowcnt: 4'h0, rxcnt: 5'h0,
    rxper: 5'h0, rxidx: 4'h0, rxsh: 11'h0, rxdata: 9'h0,
    rx_ready: 1'b0
  };

  ubt_st_t st, next_st;
  logic s_tick;
  logic rx;
  logic hold_empty;
  logic all_sent;
  logic ht;
  logic biph;
  logic [4:0] os;

  ubt_baud u_baud (
    .clk(MCLK),
    .rst_n(RESET_N),
    .div(st.baud),
    .tick(s_tick)
  );

  ubt_sync2 #(.RST_VAL(1'b1)) u_rx_sync (
    .clk(MCLK),
    .rst_n(RESET_N),
    .d(SERIAL_IN),
    .q(rx)
  );

  // flags are gated by the enable, so a stale holding state never shows
  assign hold_empty = st.tx_en && !st.thr_full;
  assign all_sent = hold_empty && st.txs == TX_IDLE;
  assign os = st.cfg[CF_OVER] ? OS8 : OS16;
  assign biph = st.cfg[CF_BIPH];
  // transmitter steps in half bits so biphase and 1.5 stop share one clock
  assign ht = s_tick && st.tdiv == 3'((os >> 1) - 5'h01);

  always_comb begin : next_logic
    logic [3:0] nbits;
    logic par_on;
    logic p;
    logic [8:0] d;
    logic [8:0] dm;
    logic load;
    logic bit_v;
    logic edge_v;
    logic [RXB_W-1:0] sh;
    logic [3:0] nrx;
    int pos;
    next_st = st;
    nbits = st.cfg[CF_NINE] ? CHR_NINE
                            : CHR_BASE + {2'h0, st.cfg[CF_CHAR_LEN +: 2]};
    par_on = st.cfg[CF_PAR +: 3] <= PAR_MARK;
    p = 1'b0;
    d = '0;
    dm = '0;
    load = 1'b0;
    bit_v = 1'b0;
    edge_v = 1'b0;
    sh = st.rxsh;
    nrx = nbits + {3'h0, par_on} + 4'h1;
    pos = 0;

    // apb: answer in the first access cycle, decoded during setup
    next_st.pready = PSEL && !PENABLE;
    next_st.pslverr = 1'b0;
    next_st.prdata = '0;
    if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CONFIG: next_st.prdata = 32'(st.cfg);
        OFS_BIPH: next_st.prdata = 32'(st.bcfg);
        OFS_BAUD: next_st.prdata = 32'(st.baud);
        OFS_RXDATA: next_st.prdata = 32'(st.rxdata);
        OFS_STATE: begin
          next_st.prdata[ST_HOLD_EMPTY] = hold_empty;
          next_st.prdata[ST_ALL_SENT] = all_sent;
          next_st.prdata[ST_RX_READY] = st.rx_ready;
          next_st.prdata[ST_TX_ON] = st.tx_en;
        end
        OFS_CTRL, OFS_THR: next_st.prdata = '0;
        default: next_st.pslverr = 1'b1;
      endcase
    end else if (PSEL && !PENABLE) begin
      case (PADDR)
        OFS_CTRL, OFS_CONFIG, OFS_BIPH, OFS_THR, OFS_BAUD: ;
        default: next_st.pslverr = 1'b1;
      endcase
    end
    if (PSEL && PENABLE && st.pready) begin
      if (PWRITE) begin
        case (PADDR)
          OFS_CONFIG: next_st.cfg = PWDATA[CFG_W-1:0];
          OFS_BIPH: next_st.bcfg = PWDATA[BCFG_W-1:0];
          OFS_BAUD: next_st.baud = PWDATA[BAUD_W-1:0];
          OFS_CTRL: begin
            if (PWDATA[CTL_TX_ON]) begin
              next_st.tx_en = 1'b1;
              next_st.off_pend = 1'b0;
            end
            if (PWDATA[CTL_TX_OFF] && next_st.tx_en) begin
              next_st.off_pend = 1'b1;
            end
          end
          OFS_THR: begin
            if (hold_empty) begin
              next_st.thr = PWDATA[8:0];
              next_st.thr_sync = PWDATA[THR_SYNC];
              next_st.thr_full = 1'b1;
            end
          end
          default: ;
        endcase
      end else if (PADDR == OFS_RXDATA) begin
        next_st.rx_ready = 1'b0;
      end
    end

    // transmitter
    if (s_tick) begin
      next_st.tdiv = ht ? 3'h0 : st.tdiv + 3'h1;
    end
    if (ht) begin
      unique case (st.txs)
        TX_IDLE: load = 1'b1;
        TX_PRE, TX_SFD, TX_BITS: begin
          next_st.hc = st.hc + 5'h01;
          if (next_st.hc == st.hend) begin
            next_st.hc = '0;
            if (st.txs == TX_PRE && !st.cfg[CF_SINGLE_DELIMITER]) begin
              next_st.txs = TX_SFD;
              next_st.hend = SYNC_HALVES;
            end else if (st.txs != TX_BITS) begin
              next_st.txs = TX_BITS;
              next_st.hend = st.blen;
            end else begin
              load = 1'b1;
            end
          end
        end
      endcase
    end
    if (load) begin
      next_st.txs = TX_IDLE;
      next_st.hc = '0;
      if (st.tx_en && st.thr_full) begin
        next_st.thr_full = 1'b0;
        for (int i = 0; i < 9; i++) begin
          if (i < int'(nbits)) begin
            dm[i] = st.thr[i];
            d[i] = st.cfg[CF_MSB_FIRST] ? st.thr[int'(nbits) - 1 - i]
                                   : st.thr[i];
          end
        end
        case (st.cfg[CF_PAR +: 3])
          PAR_EVEN: p = ^dm;
          PAR_ODD: p = ~^dm;
          PAR_SPACE: p = 1'b0;
          PAR_MARK: p = 1'b1;
          default: p = 1'b0;
        endcase
        // unused upper frame bits stay high and serve as stop bits
        next_st.fr = '1;
        if (!biph || st.cfg[CF_SINGLE_DELIMITER]) begin
          next_st.fr[0] = 1'b0;
          pos = 1;
        end
        for (int i = 0; i < 9; i++) begin
          if (i < int'(nbits)) begin
            next_st.fr[pos + i] = d[i];
          end
        end
        pos = pos + int'(nbits);
        if (par_on) begin
          next_st.fr[pos] = p;
          pos = pos + 1;
        end
        next_st.blen = 5'(2 * pos + 2);
        if (st.cfg[CF_STOP +: 2] == STOP_TWO) begin
          next_st.blen = 5'(2 * pos + 4);
        end else if (st.cfg[CF_STOP +: 2] == STOP_ONEHALF
                     && !st.cfg[CF_CLKD]) begin
          next_st.blen = 5'(2 * pos + 3);
        end
        next_st.cmd = st.cfg[CF_VARSYNC] ? st.thr_sync
                                         : st.cfg[CF_SYNCK];
        if (biph && st.bcfg[BC_PL +: 4] != 4'h0) begin
          next_st.txs = TX_PRE;
          next_st.hend = {st.bcfg[BC_PL +: 4], 1'b0};
        end else if (biph && !st.cfg[CF_SINGLE_DELIMITER]) begin
          next_st.txs = TX_SFD;
          next_st.hend = SYNC_HALVES;
        end else begin
          next_st.txs = TX_BITS;
          next_st.hend = next_st.blen;
        end
      end else if (st.off_pend && !next_st.thr_full) begin
        next_st.tx_en = 1'b0;
        next_st.off_pend = 1'b0;
      end
    end
    if (ht) begin
      unique case (next_st.txs)
        TX_IDLE: next_st.txd = 1'b1;
        TX_PRE: begin
          case (st.bcfg[BC_PP +: 2])
            PP_ALL_ONE: bit_v = 1'b1;
            PP_ALL_ZERO: bit_v = 1'b0;
            PP_ONE_ZERO: bit_v = !next_st.hc[1];
            default: bit_v = next_st.hc[1];
          endcase
          next_st.txd = bit_v ^ st.bcfg[BC_POL] ^ next_st.hc[0];
        end
        TX_SFD: begin
          next_st.txd = (next_st.hc < SYNC_HIGH) ~^ next_st.cmd;
        end
        TX_BITS: begin
          bit_v = next_st.fr[next_st.hc[4:1]];
          next_st.txd = biph ? bit_v ^ st.bcfg[BC_POL] ^ next_st.hc[0]
                             : bit_v;
        end
      endcase
    end

    // receiver
    if (s_tick) begin
      next_st.rx_prev = rx;
      edge_v = rx != st.rx_prev;
      unique case (st.rxs)
        RX_HUNT: begin
          if (rx) begin
            next_st.lowcnt = '0;
          end else if (st.lowcnt + 4'h1
                       == (st.cfg[CF_OVER] ? START8 : START16)) begin
            next_st.rxs = RX_BITS;
            next_st.lowcnt = '0;
            next_st.rxcnt = '0;
            next_st.rxidx = '0;
            next_st.rxper = os - 5'h01;
          end else begin
            next_st.lowcnt = st.lowcnt + 4'h1;
          end
        end
        RX_BITS: begin
          if (st.rxcnt == st.rxper) begin
            sh[st.rxidx] = rx;
            next_st.rxsh = sh;
            next_st.rxcnt = '0;
            next_st.rxper = os - 5'h01;
            next_st.rxidx = st.rxidx + 4'h1;
            if (next_st.rxidx == nrx) begin
              next_st.rxs = RX_HUNT;
              for (int i = 0; i < 9; i++) begin
                next_st.rxdata[i] = 1'b0;
                if (i < int'(nbits)) begin
                  next_st.rxdata[i] = st.cfg[CF_MSB_FIRST]
                    ? sh[int'(nbits) - 1 - i] : sh[i];
                end
              end
              next_st.rx_ready = 1'b1;
            end
          end else begin
            next_st.rxcnt = st.rxcnt + 5'h01;
            // a mid-bit edge is the previous bit boundary, seen late/early
            if (edge_v && st.bcfg[BC_DRIFT] && !st.cfg[CF_OVER]) begin
              if (st.rxcnt >= EARLY_LO && st.rxcnt <= EARLY_HI) begin
                next_st.rxper = os - 5'h02;
              end else if (st.rxcnt >= LATE_LO && st.rxcnt <= LATE_HI) begin
                next_st.rxper = os;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign PRDATA = st.prdata;
  assign PREADY = st.pready;
  assign PSLVERR = st.pslverr;
  assign SERIAL_OUT = st.txd;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  AST_FLAGS_OFF: assert property (
    !st.tx_en |-> !hold_empty && !all_sent)
    else $error("status flags high while transmitter off");
  AST_THR_DROP: assert property (
    PSEL && PENABLE && PWRITE && st.pready && PADDR == OFS_THR
    && st.thr_full |=> st.thr == $past(st.thr))
    else $error("write to full holding register took effect");
  AST_LOAD: assert property (
    ht && st.txs == TX_IDLE && st.tx_en && st.thr_full
    |=> !st.thr_full && st.txs != TX_IDLE)
    else $error("held character not moved to shifter");
  AST_ALL_SENT: assert property (
    all_sent |-> st.txs == TX_IDLE && !st.thr_full && SERIAL_OUT)
    else $error("all sent while a character is pending");
  AST_MID_EDGE: assert property (
    ht && biph && st.txs == TX_BITS && !st.hc[0]
    && st.hc + 5'h01 != st.hend |=> SERIAL_OUT != $past(SERIAL_OUT))
    else $error("no transition at biphase mid bit");
  AST_SYNC_SHAPE: assert property (
    st.txs == TX_SFD && st.cmd |-> SERIAL_OUT == (st.hc < SYNC_HIGH))
    else $error("command sync level wrong");
  AST_START_DET: assert property (
    s_tick && st.rxs == RX_HUNT && !rx && !st.cfg[CF_OVER]
    && st.lowcnt == START16 - 4'h1 |=> st.rxs == RX_BITS)
    else $error("start not declared at eighth low sample");
  AST_DRIFT_GATE: assert property (
    st.rxs == RX_BITS && (st.cfg[CF_OVER] || !st.bcfg[BC_DRIFT])
    |-> st.rxper == os - 5'h01)
    else $error("bit period altered without drift compensation");
  AST_IDLE_HIGH: assert property (
    st.txs == TX_IDLE ##1 st.txs == TX_IDLE |-> SERIAL_OUT)
    else $error("line not idle high between characters");
endmodule // ubt_usart
`default_nettype wire

// File: pkg/ubt_pkg.sv
// register map, field layout and codes for the serial transmitter block
// Operation
// - send start, up to nine data, optional parity, up to two stops.
// - data length from char_len; nine_bit_sel forces nine bits.
// - msb_first set sends the top bit first, else bottom bit.
// - stop bits follow stop_count; one and a half only unclocked.
// - parity bit follows check_bit_type: even, odd, space, mark, none.
// - finished character pulls holding word into shifter, holding empties.
// - all_sent_flag only when every written character left the line.
// - both status flags read low while transmitter is off.
// - holding write while it cannot accept is dropped.
// - biphase mode puts a transition mid every bit time except the first and third sync bits.
// - default polarity: zero low-to-high, one high-to-low.
// - preamble of tx_preamble_len bits with chosen pattern; zero means none.
// - single_delimiter set sends one biphase zero as delimiter.
// - otherwise three bit sync with one mid second-bit transition.
// - command sync high one and a half bits, then low.
// - sync_kind picks command or data sync.
// - per_char_sync_src takes sync kind from the holding word.
// - drift compensation only at 16x and when enabled.
// - one clock off no change; early shortens, late lengthens.
// - receiver oversamples 16x or 8x by sample_rate_sel.
// - start at eighth or fourth low sample, then one per bit.
// - receiver frames with the transmitter's length, order, parity.
// - receiver takes one stop bit and hunts right after it.
// - transmitter starts disabled; tx_on_cmd enables it.
// - tx_off_cmd waits for current and held character first.
`default_nettype none
package ubt_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned BAUD_W = 16;
  localparam int unsigned CFG_W = 15;
  localparam int unsigned BCFG_W = 8;
  localparam int unsigned FRAME_W = 13;
  localparam int unsigned RXB_W = 11;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CONFIG = 8'h04;
  localparam logic [7:0] OFS_BIPH = 8'h08;
  localparam logic [7:0] OFS_THR = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  localparam logic [7:0] OFS_RXDATA = 8'h14;
  localparam logic [7:0] OFS_BAUD = 8'h18;
  localparam int CTL_TX_ON = 0;
  localparam int CTL_TX_OFF = 1;
  localparam int CF_CHAR_LEN = 0;
  localparam int CF_NINE = 2;
  localparam int CF_PAR = 3;
  localparam int CF_MSB_FIRST = 6;
  localparam int CF_STOP = 7;
  localparam int CF_OVER = 9;
  localparam int CF_BIPH = 10;
  localparam int CF_SINGLE_DELIMITER = 11;
  localparam int CF_SYNCK = 12;
  localparam int CF_VARSYNC = 13;
  localparam int CF_CLKD = 14;
  localparam int BC_PL = 0;
  localparam int BC_PP = 4;
  localparam int BC_POL = 6;
  localparam int BC_DRIFT = 7;
  localparam int THR_SYNC = 15;
  localparam int ST_HOLD_EMPTY = 0;
  localparam int ST_ALL_SENT = 1;
  localparam int ST_RX_READY = 2;
  localparam int ST_TX_ON = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 15'h0023;
  localparam logic [BCFG_W-1:0] BCFG_RST = 8'h00;
  localparam logic [BAUD_W-1:0] BAUD_RST = 16'h0001;
  localparam logic [3:0] CHR_BASE = 4'h5;
  localparam logic [3:0] CHR_NINE = 4'h9;
  localparam logic [2:0] PAR_EVEN = 3'h0;
  localparam logic [2:0] PAR_ODD = 3'h1;
  localparam logic [2:0] PAR_SPACE = 3'h2;
  localparam logic [2:0] PAR_MARK = 3'h3;
  localparam logic [1:0] STOP_ONEHALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [1:0] PP_ALL_ONE = 2'h0;
  localparam logic [1:0] PP_ALL_ZERO = 2'h1;
  localparam logic [1:0] PP_ONE_ZERO = 2'h2;
  localparam logic [4:0] OS16 = 5'h10;
  localparam logic [4:0] OS8 = 5'h08;
  localparam logic [3:0] START16 = 4'h8;
  localparam logic [3:0] START8 = 4'h4;
  localparam logic [4:0] SYNC_HALVES = 5'h06;
  localparam logic [4:0] SYNC_HIGH = 5'h03;
  localparam logic [4:0] EARLY_LO = 5'h03;
  localparam logic [4:0] EARLY_HI = 5'h05;
  localparam logic [4:0] LATE_LO = 5'h09;
  localparam logic [4:0] LATE_HI = 5'h0a;
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1, TX_PRE = 4'h2, TX_SFD = 4'h4, TX_BITS = 4'h8
  } ubt_tx_t;
  typedef enum logic [1:0] {RX_HUNT = 2'h1, RX_BITS = 2'h2} ubt_rx_t;
endpackage
`default_nettype wire

// File: core/ubt_sync2.sv
// two flip-flop synchroniser for the serial input pin
`default_nettype none
module ubt_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous level in, synchronous level out
  input wire logic d,
  output logic q
);
  import ubt_pkg::*;
  typedef struct packed {logic meta; logic q;} ubt_sync_st_t;
  ubt_sync_st_t st, next_st;
  always_comb begin
    next_st.meta = d;
    next_st.q = st.meta;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{meta: RST_VAL, q: RST_VAL};
    end else begin
      st <= next_st;
    end
  end
  assign q = st.q;
endmodule // ubt_sync2
`default_nettype wire

// File: core/ubt_baud.sv
// divider making the one-cycle oversampling enable pulse
`default_nettype none
module ubt_baud (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // divisor; zero behaves as one
  input wire logic [ubt_pkg::BAUD_W-1:0] div,
  // sample pulse
  output logic tick
);
  import ubt_pkg::*;
  typedef struct packed {
    logic [BAUD_W-1:0] cnt;
    logic tick;
  } ubt_baud_st_t;
  ubt_baud_st_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    next_st.cnt = st.cnt + 1'b1;
    if (div <= BAUD_RST || st.cnt >= div - 1'b1) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{cnt: '0, tick: 1'b0};
    end else begin
      st <= next_st;
    end
  end
  assign tick = st.tick;
endmodule // ubt_baud
`default_nettype wire

// File: tb/ubt_remote.sv
// remote serial transceiver model facing the line pins
`default_nettype none
module ubt_remote #(
  parameter int HALF = 8
) (
  // clock
  input wire logic clk,
  // line pins
  input wire logic line_out,
  output logic line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed = 1'b0;
  logic active = 1'b0;
  int cnt = 0;
  int nh = 0;
  int want = 0;
  logic [63:0] halves = '0;
  initial line_in = 1'b1;
  // sample mid half bit; the first low after idle sets the phase
  always @(posedge clk) begin
    if (armed && !active && line_out === 1'b0) begin
      active <= 1'b1;
      cnt <= 1;
      nh <= 0;
    end else if (active) begin
      cnt <= cnt + 1;
      if (cnt % HALF == HALF / 2 - 1) begin
        halves <= {halves[62:0], line_out};
        nh <= nh + 1;
        if (nh + 1 == want) begin
          active <= 1'b0;
          armed <= 1'b0;
        end
      end
    end
  end
  task automatic arm(input int n);
    @(posedge clk);
    want <= n;
    armed <= 1'b1;
  endtask
  // one start, eight data lsb first, one stop; a bit is two half bits
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      line_in <= f[i];
      repeat (2 * HALF - 1) @(posedge clk);
    end
  endtask
endmodule // ubt_remote
`default_nettype wire

// File: tb/usart_tx_biphase_async_rx_tb.sv
// self-checking bench: apb register access, line framing, receive path
`default_nettype none
module usart_tx_biphase_async_rx_tb;
  import ubt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ser_in;
  logic ser_out;
  logic [31:0] r;
  logic err;
  int fails = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  ubt_usart dut_u (.MCLK(clk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SERIAL_IN(ser_in), .SERIAL_OUT(ser_out));
  // dut runs one sample tick per clock, so a half bit is 8 clocks
  ubt_remote #(.HALF(8)) remote_u (.clk(clk), .line_out(ser_out),
    .line_in(ser_in));
  task automatic results;
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    // a slave that never answers counts as a mismatch
    if (pready !== 1'b1) begin
      fails++;
      $display("MISMATCH pready expected 1 seen %b", pready);
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_cap;
    int n;
    n = 0;
    while (remote_u.armed !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (remote_u.armed !== 1'b0) begin
      fails++;
      $display("MISMATCH capture expected 0 seen %b", remote_u.armed);
    end
  endtask
  // plain frame as half bits: start, data lsb first, one stop
  function automatic logic [19:0] nrz(input logic [7:0] b);
    logic [19:0] v;
    v = 20'h00003;
    for (int i = 0; i < 8; i++)
      v[17-2*i -: 2] = {2{b[i]}};
    return v;
  endfunction
  // zero-one preamble of two bits, sync, msb first data, coded stop
  function automatic logic [27:0] bip(input logic [7:0] b,
                                      input logic cmd);
    logic [27:0] v;
    v = {4'b0110, cmd ? 6'b111000 : 6'b000111, 18'h00002};
    for (int i = 0; i < 8; i++)
      v[17-2*i -: 2] = b[7-i] ? 2'b10 : 2'b01;
    return v;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFS_CONFIG, 32'h0);
    chk("config reset", 64'(CFG_RST), 64'(r));
    apb(1'b0, OFS_BIPH, 32'h0);
    chk("biphase reset", 64'(BCFG_RST), 64'(r));
    apb(1'b0, OFS_BAUD, 32'h0);
    chk("baud reset", 64'(BAUD_RST), 64'(r));
    apb(1'b1, OFS_THR, 32'h41);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("state disabled", 64'h0, 64'(r));
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 64'h1, 64'(err));
    chk("unmapped data", 64'h0, 64'(r));
    // two characters back to back, third refused while holding is full
    remote_u.arm(40);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_THR, 32'ha5);
    repeat (10) @(posedge clk);
    apb(1'b1, OFS_THR, 32'h3c);
    apb(1'b1, OFS_THR, 32'hff);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("state busy", 64'h8, 64'(r));
    apb(1'b1, OFS_CTRL, 32'h2);
    wait_cap();
    chk("nrz pair", {24'h0, nrz(8'ha5), nrz(8'h3c)},
        {24'h0, remote_u.halves[39:0]});
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_STATE, 32'h0);
    chk("state stopped", 64'h0, 64'(r));
    remote_u.arm(1);
    repeat (300) @(posedge clk);
    chk("no dropped char", 64'h0, 64'(remote_u.active));
    // receive path at 16x
    remote_u.send(8'h5a);
    repeat (10) @(posedge clk);
    apb(1'b0, OFS_RXDATA, 32'h0);
    chk("rx data", 64'h5a, 64'(r));
    // biphase: data sync then command sync taken from each word
    apb(1'b1, OFS_CONFIG, 32'h2463);
    apb(1'b1, OFS_BIPH, 32'h32);
    remote_u.arm(56);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_THR, 32'h00b1);
    repeat (10) @(posedge clk);
    apb(1'b1, OFS_THR, 32'h80b1);
    wait_cap();
    chk("biphase pair", {8'h0, bip(8'hb1, 1'b0), bip(8'hb1, 1'b1)},
        {8'h0, remote_u.halves[55:0]});
    results();
  end
endmodule // usart_tx_biphase_async_rx_tb
`default_nettype wire
